/* hdl/pcr_regs.svh */
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PCR_ADDR_FLAGS      16'hc000
`define PCR_ADDR_BASE       16'hc002
`define PCR_ADDR_REV        16'hc004
`define PCR_ADDR_DIV        16'hc008
`define PCR_ADDR_PWR        16'hc00a

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define PCR_FLAG_GIE        4
`define PCR_FLAG_NEG        3
`define PCR_FLAG_OVF        2
`define PCR_FLAG_CARRY      1
`define PCR_FLAG_ZERO       0
`define PCR_BASE_MASK       16'hfff0
`define PCR_DIV_MASK        16'h000f
`define PCR_PWR_WMASK       16'hfb93
`define PCR_PWR_WAKE_MASK   16'hfb90
`define PCR_PWR_PORT2B      15
`define PCR_PWR_PORT2A      14
`define PCR_PWR_PORT1B      13
`define PCR_PWR_PORT1A      12
`define PCR_PWR_BOOST       2
`define PCR_PWR_SLEEP       1
`define PCR_PWR_HALT        0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PCR_RST_BASE        16'h0100
`define PCR_RST_DIV         16'h000f
`define PCR_RST_PWR         16'h0000
`define PCR_WAKE_TIME_US    500
`define PCR_CLK_MHZ         100

`endif

/* hdl/pcr_pkg.sv */
package pcr_pkg;
    typedef enum logic [2:0]
    {
        PCR_RUN   = 3'b001,
        PCR_SLEEP = 3'b010,
        PCR_WAKE  = 3'b100
    } pcr_pwr_state_t;
endpackage

/* hdl/pcr_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// CPU clock enable divider, divide by code plus one
// ****************************************************************
module pcr_clkdiv #(
    parameter int DIV_W = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             run_i,
    input  wire logic [DIV_W-1:0] div_i,
    output logic                  tick_o
);
    logic [DIV_W-1:0] count;
    wire              wrap = (count >= div_i);

    initial
    begin
        if (DIV_W < 1 || DIV_W > 8)
            $error("pcr_clkdiv: DIV_W out of range");
    end

    // Counter frozen while stopped so a resume keeps the phase
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            count <= '0;
        else if (run_i)
            count <= wrap ? '0 : count + 1'b1;
    end

    assign tick_o = run_i & wrap;
endmodule

`default_nettype wire

/* hdl/pcr_top.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"

// Summary of operation
// [RULE_01] Flags register is a read-only view; writes leave flags alone.
// [RULE_02] Flag bit 4 shows global interrupt enable.
// [RULE_03] Negative flag bit 3 follows MSB of last arithmetic result.
// [RULE_04] Overflow flag bit 2 set on signed add/sub overflow, else cleared.
// [RULE_05] Carry flag bit 1 set on carry or borrow, else cleared.
// [RULE_06] Zero flag bit 0 set when result is zero, else cleared.
// [RULE_07] Register-file base is read-write, resets to 0x0100.
// [RULE_08] General register address = base[15:4] OR (index<<1), bit 0 zero.
// [RULE_09] Software writes zeros to reserved base and divisor bits.
// [RULE_10] Read-only 16-bit silicon revision code.
// [RULE_11] CPU runs at clock divided by divisor plus one; resets to 1111.
// [RULE_12] Divisor slows the CPU only; peripherals keep the full clock.
// [RULE_13] Power register selects sleep or halt; other writable bits enable wakeups.
// [RULE_14] Bit 15 enables wake on port 2B transitions, else ignored.
// [RULE_15] Port transition wakeups raise no interrupt to the CPU.
// [RULE_16] Bits 14, 13, 12 enable wake on ports 2A, 1B, 1A.
// [RULE_17] Bit 1 enters sleep at once; wakeup resumes within 0.5 ms.
// [RULE_18] Bit 0 halts the CPU only, until an enabled interrupt fires.
// [RULE_19] Power bit 2 is read-only booster rail status.
// [RULE_20] Read-only and reserved bits ignore writes; reserved reads are zero.
module pcr_top #(
    parameter logic [15:0] REVISION   = 16'h0a5c, // Arbitrary value
    parameter int          WAKE_DELAY = (`PCR_WAKE_TIME_US * `PCR_CLK_MHZ)
) (
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RESETN_I,
    // APB slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [15:0]           PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    input  wire logic [3:0]            PSTRB_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // Processor flag inputs
    input  wire logic                  ALU_UPDATE_I,
    input  wire logic                  ALU_IS_SUB_I,
    input  wire logic [15:0]           ALU_A_I,
    input  wire logic [15:0]           ALU_B_I,
    input  wire logic                  ALU_ARITH_I,
    input  wire logic                  GIE_I,
    // Register-file address generation
    input  wire logic [3:0]            GREG_INDEX_I,
    output logic      [15:0]           GREG_ADDR_O,
    // Power and wake inputs, clock enable and status outputs
    input  wire logic [3:0]            USB_PORT_ACTIVITY_I,
    input  wire logic [6:0]            OTHER_WAKE_I,
    input  wire logic                  IRQ_PENDING_I,
    input  wire logic                  BOOSTER_RAIL_LOW_I,
    output logic                       CPU_CLK_EN_O,
    output logic                       PERIPH_CLK_EN_O,
    output logic                       SLEEPING_O,
    output logic                       HALTED_O,
    output pcr_pkg::pcr_pwr_state_t    PWR_STATE_O
);
    import pcr_pkg::*;

    localparam int WAKE_W = $clog2(WAKE_DELAY + 1);

    initial
    begin
        if (WAKE_DELAY < 1)
            $error("pcr_top: WAKE_DELAY must be at least one cycle");
        if (WAKE_DELAY > `PCR_WAKE_TIME_US * `PCR_CLK_MHZ)
            $error("pcr_top: WAKE_DELAY exceeds the resume limit");
    end

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] r);
        addr_is = (a[15:1] == r[15:1]) && (a[0] == 1'b0);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  strb,
                                            input logic [15:0] wmask);
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge16 = (old & ~lane) | (wd & lane);
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire        access   = PSEL_I & PENABLE_I;
    wire        setup    = PSEL_I & ~PENABLE_I;
    wire        wr_en    = access & PWRITE_I;
    wire        sel_flag = addr_is(PADDR_I, `PCR_ADDR_FLAGS);
    wire        sel_base = addr_is(PADDR_I, `PCR_ADDR_BASE);
    wire        sel_rev  = addr_is(PADDR_I, `PCR_ADDR_REV);
    wire        sel_div  = addr_is(PADDR_I, `PCR_ADDR_DIV);
    wire        sel_pwr  = addr_is(PADDR_I, `PCR_ADDR_PWR);
    wire        mapped   = sel_flag | sel_base | sel_rev | sel_div | sel_pwr;
    wire [1:0]  strb     = PSTRB_I[1:0];
    wire [15:0] wdata    = PWDATA_I[15:0];

    // Zero-wait slave; unmapped addresses raise an error
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access & ~mapped;

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [3:0]      flags;
    logic [15:0]     base;
    logic [15:0]     divisor;
    logic [15:0]     pwr;
    logic [15:0]     rdata;
    logic [WAKE_W-1:0] wake_cnt;
    logic [3:0]      port_prev;
    logic [6:0]      other_prev;
    pcr_pwr_state_t  state;
    pcr_pwr_state_t  next_state;

    // ****************************************************************
    // Flag computation
    // ****************************************************************
    wire [16:0] sum      = ALU_IS_SUB_I ? ({1'b0, ALU_A_I} - {1'b0, ALU_B_I})
                                        : ({1'b0, ALU_A_I} + {1'b0, ALU_B_I});
    wire        ovf_add  = (ALU_A_I[15] == ALU_B_I[15]) && (sum[15] != ALU_A_I[15]);
    wire        ovf_sub  = (ALU_A_I[15] != ALU_B_I[15]) && (sum[15] != ALU_A_I[15]);
    wire        next_neg = sum[15];                                   // [RULE_03]
    wire        next_ovf = ALU_IS_SUB_I ? ovf_sub : ovf_add;          // [RULE_04]
    wire        next_cy  = sum[16];                                   // [RULE_05]
    wire        next_z   = (sum[15:0] == 16'h0000);                   // [RULE_06]

    // Only the ALU updates flags; bus writes never reach them
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
            flags[3:0] <= 4'h0;
        else if (ALU_UPDATE_I && ALU_ARITH_I)
            flags[3:0] <= {next_neg, next_ovf, next_cy, next_z};      // [RULE_01]
        else if (ALU_UPDATE_I)
            flags[3:0] <= {next_neg, 1'b0, 1'b0, next_z};
    end

    // Interrupt enable mirrored live from the core, not stored here
    wire [4:0] flag_view = {GIE_I, flags};                            // [RULE_02]

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    // Masks drop reserved and read-only bits even if software sets them
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
        begin
            base    <= `PCR_RST_BASE;                                 // [RULE_07]
            divisor <= `PCR_RST_DIV;                                  // [RULE_11]
        end
        else
        begin
            if (wr_en && sel_base)
                base <= merge16(base, wdata, strb, `PCR_BASE_MASK);   // [RULE_20]
            if (wr_en && sel_div)
                divisor <= merge16(divisor, wdata, strb, `PCR_DIV_MASK);
        end
    end

    // Sleep and halt bits self-clear when their mode ends
    wire        pwr_wr     = wr_en & sel_pwr;
    wire [15:0] pwr_merged = merge16(pwr, wdata, strb, `PCR_PWR_WMASK); // [RULE_13]
    wire        sleep_req  = pwr_wr & pwr_merged[`PCR_PWR_SLEEP];
    wire        halt_end   = pwr[`PCR_PWR_HALT] & IRQ_PENDING_I;      // [RULE_18]

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
            pwr <= `PCR_RST_PWR;
        else if (pwr_wr)
            pwr <= pwr_merged;
        else
        begin
            if (state == PCR_WAKE && next_state == PCR_RUN)
                pwr[`PCR_PWR_SLEEP] <= 1'b0;
            if (halt_end)
                pwr[`PCR_PWR_HALT] <= 1'b0;
        end
    end

    // ****************************************************************
    // Wake source detection
    // ****************************************************************
    // Any edge on a port counts as a transition
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
        begin
            port_prev  <= 4'h0;
            other_prev <= 7'h00;
        end
        else
        begin
            port_prev  <= USB_PORT_ACTIVITY_I;
            other_prev <= OTHER_WAKE_I;
        end
    end

    wire [10:0] wake_in   = {OTHER_WAKE_I, USB_PORT_ACTIVITY_I};
    wire [10:0] wake_last = {other_prev, port_prev};
    wire [10:0] wake_edge;

    // Same toggle detector on every source; a held level never wakes
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1)
        begin : g_edge
            assign wake_edge[gi] = wake_in[gi] ^ wake_last[gi];
        end
    endgenerate

    wire [3:0] port_edge = wake_edge[3:0];
    wire [6:0] oth_edge  = wake_edge[10:4];
    // Port order 1A,1B,2A,2B matches enable bits 12..15
    wire [3:0] port_en   = pwr[`PCR_PWR_PORT2B:`PCR_PWR_PORT1A];      // [RULE_14] [RULE_16]
    wire [6:0] oth_en    = {pwr[11], pwr[9], pwr[8], pwr[7], pwr[4], 2'b00};
    // Wake only restarts clocks; nothing here feeds an interrupt line
    wire       wake_hit  = |(port_edge & port_en) | |(oth_edge & oth_en); // [RULE_15]

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            PCR_RUN:
                if (sleep_req)
                    next_state = PCR_SLEEP;                           // [RULE_17]
            PCR_SLEEP:
                if (wake_hit)
                    next_state = PCR_WAKE;
            PCR_WAKE:
                if (wake_cnt == WAKE_W'(WAKE_DELAY - 1))
                    next_state = PCR_RUN;
            default:
                next_state = PCR_RUN;
        endcase
    end

    // Resume delay models PLL relock, kept within the 0.5 ms limit
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
        begin
            state    <= PCR_RUN;
            wake_cnt <= '0;
        end
        else
        begin
            state    <= next_state;
            wake_cnt <= (state == PCR_WAKE) ? wake_cnt + 1'b1 : '0;  // [RULE_17]
        end
    end

    wire clk_run = (state == PCR_RUN);
    wire cpu_run = clk_run & ~pwr[`PCR_PWR_HALT];                     // [RULE_18]
    wire div_tick;

    // ****************************************************************
    // CPU clock divider
    // ****************************************************************
    pcr_clkdiv #(
        .DIV_W (4)
    ) u_clkdiv (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESETN_I),
        .run_i   (cpu_run),
        .div_i   (divisor[3:0]),                                      // [RULE_11]
        .tick_o  (div_tick)
    );

    // Peripherals see the full rate, stopped in the sleep and wake states
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
        begin
            CPU_CLK_EN_O    <= 1'b0;
            PERIPH_CLK_EN_O <= 1'b0;
            SLEEPING_O      <= 1'b0;
            HALTED_O        <= 1'b0;
            PWR_STATE_O     <= PCR_RUN;
        end
        else
        begin
            CPU_CLK_EN_O    <= div_tick;
            PERIPH_CLK_EN_O <= clk_run;                               // [RULE_12]
            SLEEPING_O      <= ~clk_run;
            HALTED_O        <= pwr[`PCR_PWR_HALT];
            PWR_STATE_O     <= state;
        end
    end

    // ****************************************************************
    // General register address
    // ****************************************************************
    wire [15:0] greg_addr = (base & `PCR_BASE_MASK) | {11'h000, GREG_INDEX_I, 1'b0};

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
            GREG_ADDR_O <= 16'h0000;
        else
            GREG_ADDR_O <= greg_addr;                                 // [RULE_08]
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Reserved bits read zero; booster status is live
    wire [15:0] pwr_view = (pwr & `PCR_PWR_WMASK)
                         | {13'h0000, BOOSTER_RAIL_LOW_I, 2'b00};     // [RULE_19]

    always_comb
    begin
        rdata = 16'h0000;
        if (sel_flag)
            rdata = {11'h000, flag_view};
        else if (sel_base)
            rdata = base & `PCR_BASE_MASK;                            // [RULE_20]
        else if (sel_rev)
            rdata = REVISION;                                         // [RULE_10]
        else if (sel_div)
            rdata = divisor & `PCR_DIV_MASK;
        else if (sel_pwr)
            rdata = pwr_view;
    end

    // Captured in the setup cycle, so a change in the access cycle shows next read
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I)
            PRDATA_O <= 32'h0000_0000;
        else if (setup)
            PRDATA_O <= {16'h0000, rdata};
    end
endmodule

`default_nettype wire

/* tb/pcr_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"

// ****************************************************************
// Bus, flag view and power sequencing checker
// ****************************************************************
module pcr_top_checker
    import pcr_pkg::*;
#(
    parameter logic [15:0] REVISION   = 16'h0000,
    parameter int          WAKE_DELAY = 10
)
(
    input wire logic                  REF_CLK_I,
    input wire logic                  RESETN_I,
    input wire logic                  PSEL_I,
    input wire logic                  PENABLE_I,
    input wire logic                  PWRITE_I,
    input wire logic [15:0]           PADDR_I,
    input wire logic [31:0]           PWDATA_I,
    input wire logic [3:0]            PSTRB_I,
    input wire logic [31:0]           PRDATA_O,
    input wire logic                  PREADY_O,
    input wire logic                  PSLVERR_O,
    input wire logic                  GIE_I,
    input wire logic [3:0]            GREG_INDEX_I,
    input wire logic [15:0]           GREG_ADDR_O,
    input wire logic                  CPU_CLK_EN_O,
    input wire logic                  PERIPH_CLK_EN_O,
    input wire logic                  HALTED_O,
    input wire pcr_pkg::pcr_pwr_state_t PWR_STATE_O
);
    // Access phase and address decode
    wire acc = PSEL_I & PENABLE_I;
    wire mapped = PADDR_I inside {`PCR_ADDR_FLAGS, `PCR_ADDR_BASE, `PCR_ADDR_REV,
                                  `PCR_ADDR_DIV, `PCR_ADDR_PWR};
    wire rd_acc = acc & ~PWRITE_I;
    logic [15:0] wake_cnt;

    // Cycles spent waking; a stuck wake state shows as a runaway count
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESETN_I || PWR_STATE_O != PCR_WAKE)
            wake_cnt <= 16'h0000;
        else
            wake_cnt <= wake_cnt + 16'h0001;
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence sleep_wr;
        acc && PWRITE_I && PADDR_I == `PCR_ADDR_PWR && PSTRB_I[0] && PWDATA_I[1]
            && PWR_STATE_O == PCR_RUN;
    endsequence

    ready_always_a: assert property (PREADY_O) else $error("ready low");
    unmapped_err_a: assert property (acc && !mapped |-> PSLVERR_O)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (rd_acc && mapped |-> !PSLVERR_O && PRDATA_O[31:16] == 16'h0)
        else $error("bad mapped read");
    gie_live_a: assert property (rd_acc && PADDR_I == `PCR_ADDR_FLAGS
        |-> PRDATA_O[4] == $past(GIE_I))
        else $error("interrupt enable flag wrong");
    rev_read_a: assert property (rd_acc && PADDR_I == `PCR_ADDR_REV
        |-> PRDATA_O[15:0] == REVISION)
        else $error("revision wrong");
    greg_low_a: assert property ($past(RESETN_I) |->
        GREG_ADDR_O[3:0] == {$past(GREG_INDEX_I[2:0]), 1'b0}
            && (GREG_ADDR_O[4] || !$past(GREG_INDEX_I[3])))
        else $error("register address low bits wrong");
    sleep_enter_a: assert property (sleep_wr |-> ##2 PWR_STATE_O == PCR_SLEEP)
        else $error("sleep not entered");
    periph_off_a: assert property ((PWR_STATE_O == PCR_SLEEP) [*2]
        |-> !PERIPH_CLK_EN_O)
        else $error("peripheral clock runs in sleep");
    periph_run_a: assert property ((PWR_STATE_O == PCR_RUN) [*3] |-> PERIPH_CLK_EN_O)
        else $error("peripheral clock stopped");
    halt_stop_a: assert property (HALTED_O [*2] |-> !CPU_CLK_EN_O)
        else $error("cpu ticks while halted");
    sleep_stop_a: assert property ((PWR_STATE_O != PCR_RUN) [*2] |-> !CPU_CLK_EN_O)
        else $error("cpu ticks while asleep");
    wake_len_a: assert property (wake_cnt <= WAKE_DELAY + 1)
        else $error("wake takes too long");
endmodule

bind pcr_top pcr_top_checker #(.REVISION(REVISION), .WAKE_DELAY(WAKE_DELAY)) u_pcr_top_checker (
    .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .GIE_I(GIE_I),
    .GREG_INDEX_I(GREG_INDEX_I), .GREG_ADDR_O(GREG_ADDR_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
    .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .HALTED_O(HALTED_O), .PWR_STATE_O(PWR_STATE_O));

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"

// ****************************************************************
// Self-checking bench
// ****************************************************************
module tb_top;
    import pcr_pkg::*;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [15:0] paddr = 0, a = 0, b = 0;
    logic [31:0] pwdata = 0, rs = 32'h719a7408;
    logic [3:0]  pstrb = 4'h3, idx = 0;
    logic        upd = 0, sub = 0, ar = 0, gie = 0, irq = 0, boost = 0;
    logic [10:0] wv = 0;
    wire logic [31:0] prdata;
    wire logic [15:0] gaddr;
    wire logic   pready, perr, cpuen, peren, slp, hlt;
    wire pcr_pwr_state_t st;
    int          err_count = 0, checked = 0;
    logic [32:0] q[$];

    always #5 clk = ~clk;

    // Short wake delay keeps the run brief
    pcr_top #(.REVISION(16'h1234), .WAKE_DELAY(10)) u_pcr_top (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(perr), .ALU_UPDATE_I(upd), .ALU_IS_SUB_I(sub),
        .ALU_A_I(a), .ALU_B_I(b), .ALU_ARITH_I(ar), .GIE_I(gie), .GREG_INDEX_I(idx),
        .GREG_ADDR_O(gaddr), .USB_PORT_ACTIVITY_I(wv[3:0]), .OTHER_WAKE_I(wv[10:4]),
        .IRQ_PENDING_I(irq), .BOOSTER_RAIL_LOW_I(boost), .CPU_CLK_EN_O(cpuen),
        .PERIPH_CLK_EN_O(peren), .SLEEPING_O(slp), .HALTED_O(hlt), .PWR_STATE_O(st));

    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for ready, releases only after it
    task apb(input logic w, input logic [15:0] ad, input logic [31:0] d,
             input logic [3:0] s = 4'h3);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwdata <= d; pstrb <= s;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); end while (pready !== 1'b1);
        psel <= 0; pen <= 0;
    endtask

    task rd(input logic [15:0] ad, input logic [32:0] e);
        q.push_back(e);
        apb(0, ad, 0);
    endtask

    // Cycles between two divided cpu ticks
    task gap(output int n);
        n = 0;
        while (cpuen !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        @(posedge clk);
        n = 1;
        while (cpuen !== 1'b1 && n < 40) begin @(posedge clk); n++; end
    endtask

    task tally_and_finish;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read data compared at the sampling edge of each read
    always @(posedge clk)
        if (psel && pen && pready === 1'b1 && !pwr && q.size() > 0)
            chk({perr, prdata}, q.pop_front());

    // Hang guard, well beyond the expected length of the run
    initial
    begin
        repeat (30000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end

    initial
    begin
        int i, j, n, en, src, o;
        logic [15:0] va, vb;
        logic [16:0] r;
        logic s, ov;
        logic [32:0] e;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd(`PCR_ADDR_BASE, 33'h100);
        rd(`PCR_ADDR_DIV, 33'hf);
        rd(`PCR_ADDR_PWR, 33'h0);
        rd(16'hc006, 33'h1_0000_0000);
        $display("reset values done");
        boost <= 1;
        for (i = 0; i < 6; i++)
            apb(1, i < 5 ? 16'hc000 + 16'(2 * i) : 16'hc00c,
                i == 1 ? 32'hfff0 : i == 4 ? 32'hf : 32'hffff_ffff);
        apb(1, `PCR_ADDR_PWR, 32'h046c);
        rd(`PCR_ADDR_REV, 33'h1234);
        rd(`PCR_ADDR_BASE, 33'hfff0);
        rd(`PCR_ADDR_DIV, 33'hf);
        rd(`PCR_ADDR_PWR, 33'h4);
        apb(1, `PCR_ADDR_BASE, 32'h0, 4'h1);
        rd(`PCR_ADDR_BASE, 33'hff00);
        $display("access kinds done");
        // Random operands, with equal operands and signed limits forced now and then
        for (i = 0; i < 24; i++)
        begin
            va = (i % 4 == 1) ? 16'h7fff : 16'(rnd());
            vb = (i % 4 == 0) ? va : (i % 4 == 1) ? 16'h1 : 16'(rnd());
            s = (i % 4 == 1) ? 1'b0 : 1'(rnd());
            @(posedge clk);
            a <= va; b <= vb; sub <= s; ar <= (i % 5 != 4); gie <= va[9]; upd <= 1;
            @(posedge clk);
            upd <= 0;
            r = s ? {1'b0, va} - {1'b0, vb} : {1'b0, va} + {1'b0, vb};
            ov = (s ? va[15] != vb[15] : va[15] == vb[15]) && r[15] != va[15];
            e = {28'h0, va[9], r[15], ar & ov, ar & r[16], r[15:0] == 16'h0};
            rd(`PCR_ADDR_FLAGS, e);
        end
        apb(1, `PCR_ADDR_FLAGS, 32'h0);
        rd(`PCR_ADDR_FLAGS, e);
        $display("flags done");
        for (i = 0; i < 16; i++)
        begin
            va = 16'(rnd());
            apb(1, `PCR_ADDR_BASE, {16'h0, va & 16'hfff0});
            idx <= i[3:0];
            repeat (2) @(posedge clk);
            chk(gaddr, (va & 16'hfff0) | 16'(i << 1));
        end
        $display("register address done");
        for (i = 0; i < 16; i++)
        begin
            apb(1, `PCR_ADDR_DIV, i);
            gap(n);
            gap(n);
            chk(n, i + 1);
            chk(peren, 1);
        end
        $display("divisor done");
        apb(1, `PCR_ADDR_DIV, 0);
        apb(1, `PCR_ADDR_PWR, 32'h1);
        repeat (3) @(posedge clk);
        chk(hlt, 1);
        chk(peren, 1);
        irq <= 1;
        n = 0;
        while (hlt !== 1'b0 && n < 20) begin @(posedge clk); n++; end
        irq <= 0;
        rd(`PCR_ADDR_PWR, 33'h4);
        $display("halt done");
        // Each wake source in turn, with a disabled one poked first
        for (i = 0; i < 9; i++)
        begin
            en = i < 4 ? 12 + i : i == 4 ? 4 : i == 5 ? 7 : i == 6 ? 8 : i == 7 ? 9 : 11;
            src = i < 4 ? i : i + 2;
            j = (i + 1) % 9;
            o = j < 4 ? j : j + 2;
            apb(1, `PCR_ADDR_PWR, (1 << en) | 2);
            repeat (2) @(posedge clk);
            chk({slp, st}, {1'b1, PCR_SLEEP});
            wv[o] <= 1;
            repeat (3) @(posedge clk);
            wv[o] <= 0;
            repeat (3) @(posedge clk);
            chk(st, PCR_SLEEP);
            wv[src] <= 1;
            n = 0;
            while (st !== PCR_RUN && n < 100) begin @(posedge clk); n++; end
            chk(st, PCR_RUN);
            wv <= 0;
            rd(`PCR_ADDR_PWR, (1 << en) | 4);
        end
        $display("sleep and wake done");
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd(`PCR_ADDR_BASE, 33'h100);
        rd(`PCR_ADDR_DIV, 33'hf);
        rd(`PCR_ADDR_PWR, 33'h4);
        $display("second reset done");
        tally_and_finish;
    end
endmodule

`default_nettype wire
